// *** src/plpc_regs.sv ***
// Loop compensation and phase/sense/share configuration bytes of a two-channel controller.
// Assumes a same-clock protocol engine delivering one-cycle requests; run, sync and
// share-clock pins arrive asynchronously; input-voltage comparisons come from same-clock logic.
`timescale 1ns/1ps
`default_nettype none
module plpc_regs #(
    parameter int NCH = plpc_pkg::NUM_CHAN
) (
    input  wire logic                             clk,
    input  wire logic                             resetn,
    input  wire plpc_pkg::plpc_req_s              req,
    output var  plpc_pkg::plpc_rsp_s              rsp_q,
    input  wire logic [NCH-1:0]                   run_pin,
    input  wire logic [NCH-1:0]                   chan_cmd_on,
    input  wire logic                             vin_above_on,
    input  wire logic                             vin_below_off,
    input  wire logic                             busy_fault_clr,
    input  wire logic                             sync_clk,
    input  wire logic                             share_clk_in,
    output var  logic                             share_clk_out_q,
    output var  logic                             share_clk_oe_q,
    output var  logic                             share_clk_level_q,
    output var  logic                             phase_ref_q,
    output var  logic                             busy_fault_q,
    output var  logic [NCH-1:0][2:0]              gm_code_q,
    output var  logic [NCH-1:0][4:0]              res_code_q,
    output var  logic [NCH-1:0][plpc_pkg::DEG_W-1:0] phase_deg_q,
    output var  logic                             feedback_share_select_q,
    output var  logic [1:0]                       sense_gain_q
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [plpc_pkg::SYNC_W-1:0] pins_s;
    logic [NCH-1:0]              run_s;
    logic                        sync_s;
    logic                        share_s;
    logic                        sync_prev_q;

    plpc_sync2 #(
        .W (plpc_pkg::SYNC_W)
    ) u_sync (
        .clk      (clk),
        .resetn   (resetn),
        .async_in ({share_clk_in, sync_clk, run_pin}),
        .sync_out (pins_s)
    );

    assign run_s   = pins_s[NCH-1:0];
    assign sync_s  = pins_s[NCH];
    assign share_s = pins_s[NCH+1];

    ////////////////////////////////////////////////////////////////////////////
    // Register storage and access

    logic [NCH-1:0][7:0] comp_q;
    logic [7:0]          cfg_q;
    logic                part_off;
    logic                hit_comp;
    logic                hit_cfg;
    logic                cfg_wr_ok;
    logic                cfg_wr_busy;

    // Off when every run pin is low or every channel is commanded off
    assign part_off    = ~(|run_s) | ~(|chan_cmd_on);
    assign hit_comp    = req.valid && (req.code == plpc_pkg::CMD_LOOP_COMP);
    assign hit_cfg     = req.valid && (req.code == plpc_pkg::CMD_PHASE_CFG);
    assign cfg_wr_ok   = hit_cfg && req.write && part_off;
    assign cfg_wr_busy = hit_cfg && req.write && !part_off;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            comp_q <= {NCH{plpc_pkg::LOOP_COMP_RESET}};
        end
        else if (hit_comp && req.write)
        begin
            comp_q[req.page] <= req.data;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cfg_q <= plpc_pkg::PHASE_CFG_RESET;
        end
        else if (cfg_wr_ok)
        begin
            cfg_q <= req.data;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rsp_q <= '0;
        end
        else
        begin
            rsp_q.valid <= req.valid;
            rsp_q.ack   <= (hit_comp || hit_cfg) && !cfg_wr_busy;
            if (hit_comp && !req.write)
            begin
                rsp_q.data <= comp_q[req.page];
            end
            else if (hit_cfg && !req.write)
            begin
                rsp_q.data <= cfg_q;
            end
            else
            begin
                rsp_q.data <= 8'h00;
            end
        end
    end

    // Set wins over a simultaneous clear
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            busy_fault_q <= 1'b0;
        end
        else if (cfg_wr_busy)
        begin
            busy_fault_q <= 1'b1;
        end
        else if (busy_fault_clr)
        begin
            busy_fault_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decoded outputs

    function automatic logic [plpc_pkg::DEG_W-1:0] phase_deg(input logic [2:0] code, input logic ch);
        logic [plpc_pkg::DEG_W-1:0] d0;
        logic [plpc_pkg::DEG_W-1:0] d1;
        case (code)
            3'h1:    begin d0 = 9'h05A; d1 = 9'h10E; end
            3'h2:    begin d0 = 9'h000; d1 = 9'h0F0; end
            3'h3:    begin d0 = 9'h000; d1 = 9'h078; end
            3'h4:    begin d0 = 9'h078; d1 = 9'h0F0; end
            3'h5:    begin d0 = 9'h03C; d1 = 9'h0F0; end
            3'h6:    begin d0 = 9'h078; d1 = 9'h12C; end
            default: begin d0 = 9'h000; d1 = 9'h0B4; end // Reserved 111b acts as 000b
        endcase
        phase_deg = ch ? d1 : d0;
    endfunction

    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++)
        begin : g_chan
            always_ff @(posedge clk or negedge resetn)
            begin
                if (!resetn)
                begin
                    gm_code_q[gi]   <= plpc_pkg::LOOP_COMP_RESET[plpc_pkg::GM_MSB:plpc_pkg::GM_LSB];
                    res_code_q[gi]  <= plpc_pkg::LOOP_COMP_RESET[plpc_pkg::RES_MSB:plpc_pkg::RES_LSB];
                    phase_deg_q[gi] <= phase_deg(plpc_pkg::PHASE_CFG_RESET[2:0], gi[0]);
                end
                else
                begin
                    gm_code_q[gi]   <= comp_q[gi][plpc_pkg::GM_MSB:plpc_pkg::GM_LSB];
                    res_code_q[gi]  <= comp_q[gi][plpc_pkg::RES_MSB:plpc_pkg::RES_LSB];
                    phase_deg_q[gi] <= phase_deg(cfg_q[plpc_pkg::PHASE_MSB:plpc_pkg::PHASE_LSB], gi[0]);
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            feedback_share_select_q <= plpc_pkg::PHASE_CFG_RESET[plpc_pkg::FB_SHARE_BIT];
            sense_gain_q            <= plpc_pkg::PHASE_CFG_RESET[plpc_pkg::GAIN_MSB:plpc_pkg::GAIN_LSB];
        end
        else
        begin
            feedback_share_select_q <= cfg_q[plpc_pkg::FB_SHARE_BIT];
            sense_gain_q            <= cfg_q[plpc_pkg::GAIN_MSB:plpc_pkg::GAIN_LSB];
        end
    end

    // Phase reference: falling edge of the sync clock
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sync_prev_q <= 1'b0;
            phase_ref_q <= 1'b0;
        end
        else
        begin
            sync_prev_q <= sync_s;
            phase_ref_q <= sync_prev_q && !sync_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared clock line hold (open drain; oe low means pulled low)

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            share_clk_oe_q <= 1'b0; // Held low from first power application
        end
        else if (cfg_q[plpc_pkg::SHARE_CLK_BIT] && vin_below_off)
        begin
            share_clk_oe_q <= 1'b0;
        end
        else if (vin_above_on)
        begin
            share_clk_oe_q <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            share_clk_out_q   <= 1'b0;
            share_clk_level_q <= 1'b0;
        end
        else
        begin
            share_clk_out_q   <= 1'b0;
            share_clk_level_q <= share_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_cfg_busy_write;
        req.valid && req.write && (req.code == plpc_pkg::CMD_PHASE_CFG) && !part_off;
    endsequence

    sequence s_refused;
        rsp_q.valid && !rsp_q.ack && busy_fault_q && $stable(cfg_q);
    endsequence

    comp_write_a: assert property (req.valid && req.write && req.code == plpc_pkg::CMD_LOOP_COMP
        |=> comp_q[$past(req.page)] == $past(req.data))
        else $error("compensation byte not stored");

    gm_drive_a: assert property (##1 gm_code_q[0] == $past(comp_q[0][7:5]) && gm_code_q[1] == $past(comp_q[1][7:5]))
        else $error("transconductance code mismatch");

    res_drive_a: assert property (##1 res_code_q[1] == $past(comp_q[1][4:0]) && res_code_q[0] == $past(comp_q[0][4:0]))
        else $error("resistor code mismatch");

    comp_read_a: assert property (req.valid && !req.write && req.code == plpc_pkg::CMD_LOOP_COMP
        |=> rsp_q.ack && rsp_q.data == $past(comp_q[req.page]))
        else $error("compensation read wrong");

    cfg_reject_a: assert property (s_cfg_busy_write |=> s_refused)
        else $error("busy config write not refused");

    cfg_accept_a: assert property (req.valid && req.write && req.code == plpc_pkg::CMD_PHASE_CFG && part_off
        |=> cfg_q == $past(req.data) && rsp_q.ack ##1 phase_deg_q[0] == phase_deg($past(cfg_q[2:0]), 1'b0))
        else $error("idle config write not applied");

    phase_ch1_a: assert property (##1 phase_deg_q[1] == phase_deg($past(cfg_q[2:0]), 1'b1))
        else $error("channel 1 phase wrong");

    fb_gain_a: assert property (##1 feedback_share_select_q == $past(cfg_q[7])
        && sense_gain_q == $past(cfg_q[6:5]))
        else $error("share or gain output wrong");

    share_pull_a: assert property (cfg_q[4] && vin_below_off |=> !share_clk_oe_q)
        else $error("share clock not pulled on undervoltage");

    share_keep_a: assert property (!cfg_q[4] && share_clk_oe_q |=> share_clk_oe_q)
        else $error("share clock pulled with hold disabled");

    share_release_a: assert property (!share_clk_oe_q && !vin_above_on |=> !share_clk_oe_q)
        else $error("share clock released early");

endmodule
`default_nettype wire

// *** src/plpc_pkg.sv ***
// Constants, field layout and carrier types of the loop/phase configuration bytes.
// Assumes a protocol engine on the same clock hands over decoded byte transfers.
// Notes on behaviour
// - Bits 7:5 pick amplifier transconductance, per channel.
// - Bits 4:0 pick compensation resistor, per channel.
// - Compensation byte moves as one data byte.
// - Bits 2:0 set both channels' phase offsets.
// - Config write accepted only while part off.
// - Write while running: refuse, discard, flag busy.
// - Bit 7 set: channel 1 uses channel 0 feedback.
// - Bits 6:5 set input current sense gain.
// - Bit 4: hold share clock until input on.
// - Bit 4: pull share clock below turn-off.
// - Bit 4 clear: only initial power-up hold.
// - Compensation byte: code D3, paged, default 70.
// - Config byte: code F5, shared, default 10.
package plpc_pkg;

    localparam logic [7:0] CMD_LOOP_COMP   = 8'hD3;
    localparam logic [7:0] CMD_PHASE_CFG   = 8'hF5;
    localparam logic [7:0] LOOP_COMP_RESET = 8'h70;
    localparam logic [7:0] PHASE_CFG_RESET = 8'h10;

    localparam int GM_MSB        = 7;
    localparam int GM_LSB        = 5;
    localparam int RES_MSB       = 4;
    localparam int RES_LSB       = 0;
    localparam int FB_SHARE_BIT  = 7;
    localparam int GAIN_MSB      = 6;
    localparam int GAIN_LSB      = 5;
    localparam int SHARE_CLK_BIT = 4;
    localparam int PHASE_MSB     = 2;
    localparam int PHASE_LSB     = 0;

    localparam int NUM_CHAN  = 2;
    localparam int DEG_W     = 9;
    localparam int SYNC_W    = 4;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic       page;
        logic [7:0] code;
        logic [7:0] data;
    } plpc_req_s;

    typedef struct packed {
        logic       valid;
        logic       ack;
        logic [7:0] data;
    } plpc_rsp_s;

endpackage

// *** src/plpc_sync2.sv ***
// Two-stage synchroniser for pin-level inputs.
// Assumes inputs are asynchronous levels; only the second stage is read outside.
`timescale 1ns/1ps
`default_nettype none
module plpc_sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         resetn,
    input  wire logic [W-1:0] async_in,
    output var  logic [W-1:0] sync_out
);

    logic [W-1:0] meta_q;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            meta_q   <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule
`default_nettype wire

// *** verif/plpc_host.sv ***
// Host-side model issuing single-byte configuration transfers.
// Assumes the register port of plpc_regs on the same clock; drives at falling edges.
`timescale 1ns/1ps
`default_nettype none
module plpc_host (
    input  wire logic                clk,
    output var  plpc_pkg::plpc_req_s req,
    input  wire plpc_pkg::plpc_rsp_s rsp_q
);
    initial req = '0;

    // One request, one data byte, then wait for the answer
    task automatic xfer(input logic wr, input logic pg, input logic [7:0] code, input logic [7:0] data,
                        output logic ack, output logic [7:0] rd, output logic got);
        got = 1'b0;
        ack = 1'b0;
        rd  = 8'h00;
        if (wr && code == plpc_pkg::CMD_PHASE_CFG)
        begin
            data[3] = 1'b0;
            if (data[6:5] == 2'b11)
                data[6:5] = 2'b10;
        end
        req <= '{valid: 1'b1, write: wr, page: pg, code: code, data: data};
        @(negedge clk);
        req <= '0;
        for (int i = 0; i < 4 && !got; i++)
        begin
            if (rsp_q.valid === 1'b1)
            begin
                got = 1'b1;
                ack = rsp_q.ack;
                rd  = rsp_q.data;
            end
            else
                @(negedge clk);
        end
        // Idle cycle so a following call never re-drives req in the same step
        @(negedge clk);
    endtask
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
// Self-checking bench for the loop and phase configuration bytes.
// Assumes plpc_regs and plpc_host; run and sense pins driven at falling edges; sync clock toggles every 100 ns from 137 ns.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic                  clk = 1'b0;
    logic                  resetn = 1'b0;
    logic                  sync_clk = 1'b0;
    logic [1:0]            run_pin = 2'b00;
    logic [1:0]            chan_cmd_on = 2'b00;
    logic                  vin_above_on = 1'b0;
    logic                  vin_below_off = 1'b0;
    logic                  busy_fault_clr = 1'b0;
    wire                   share_line;
    plpc_pkg::plpc_req_s   req;
    plpc_pkg::plpc_rsp_s   rsp_q;
    logic                  sh_out, sh_oe, sh_lvl, ph_ref, busy, fb;
    logic [1:0][2:0]       gm;
    logic [1:0][4:0]       res;
    logic [1:0][8:0]       deg;
    logic [1:0]            gain;
    int                    n_mismatch = 0;
    int                    cmp_count = 0;
    int                    cyc = 0;
    localparam logic [8:0] DEG0 [0:7] = '{9'h000, 9'h05A, 9'h000, 9'h000, 9'h078, 9'h03C, 9'h078, 9'h000};
    localparam logic [8:0] DEG1 [0:7] = '{9'h0B4, 9'h10E, 9'h0F0, 9'h078, 9'h0F0, 9'h0F0, 9'h12C, 9'h0B4};

    // Open-drain share line with pull-up
    assign share_line = sh_oe ? 1'b1 : sh_out;

    initial forever #12.5 clk = ~clk;
    initial
    begin
        #37;
        forever #100 sync_clk = ~sync_clk;
    end

    plpc_host host (.clk(clk), .req(req), .rsp_q(rsp_q));

    plpc_regs uut (
        .clk(clk), .resetn(resetn), .req(req), .rsp_q(rsp_q), .run_pin(run_pin),
        .chan_cmd_on(chan_cmd_on), .vin_above_on(vin_above_on), .vin_below_off(vin_below_off),
        .busy_fault_clr(busy_fault_clr), .sync_clk(sync_clk), .share_clk_in(share_line),
        .share_clk_out_q(sh_out), .share_clk_oe_q(sh_oe), .share_clk_level_q(sh_lvl),
        .phase_ref_q(ph_ref), .busy_fault_q(busy), .gm_code_q(gm), .res_code_q(res),
        .phase_deg_q(deg), .feedback_share_select_q(fb), .sense_gain_q(gain)
    );

    task automatic tally_and_finish();
        $display("compares %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic pg, input logic [7:0] code, input logic [7:0] data, input logic exp_ack);
        logic       ack, got;
        logic [7:0] rd;
        host.xfer(1'b1, pg, code, data, ack, rd, got);
        chk({8'h00, got}, 9'h001);
        chk({8'h00, ack}, {8'h00, exp_ack});
        repeat (2) @(negedge clk);
    endtask

    task automatic rdc(input logic pg, input logic [7:0] code, input logic [7:0] exp);
        logic       ack, got;
        logic [7:0] rd;
        host.xfer(1'b0, pg, code, 8'h00, ack, rd, got);
        chk({8'h00, got & ack}, 9'h001);
        chk({1'b0, rd}, {1'b0, exp});
    endtask

    task automatic vin(input logic above, input logic below, input logic exp_oe);
        vin_above_on  = above;
        vin_below_off = below;
        repeat (3) @(negedge clk);
        chk({8'h00, sh_oe}, {8'h00, exp_oe});
    endtask

    initial
    begin
        logic [7:0] d;
        logic       seen;
        repeat (16) @(negedge clk);
        resetn = 1'b1;
        @(negedge clk);
        chk({8'h00, sh_oe}, 9'h000);
        chk({6'h00, gm[0]}, 9'h003);
        chk({4'h0, res[1]}, 9'h010);
        chk(deg[0], 9'h000);
        chk(deg[1], 9'h0B4);
        chk({5'h00, busy, fb, gain}, 9'h000);
        rdc(1'b0, plpc_pkg::CMD_LOOP_COMP, 8'h70);
        rdc(1'b1, plpc_pkg::CMD_LOOP_COMP, 8'h70);
        rdc(1'b0, plpc_pkg::CMD_PHASE_CFG, 8'h10);
        vin(1'b1, 1'b0, 1'b1);
        for (int i = 0; i < 8; i++)
        begin
            d = {3'(i), 5'(i * 4 + 3)};
            wr(1'b0, plpc_pkg::CMD_LOOP_COMP, d, 1'b1);
            wr(1'b1, plpc_pkg::CMD_LOOP_COMP, ~d, 1'b1);
            chk({6'h00, gm[0]}, {6'h00, d[7:5]});
            chk({6'h00, gm[1]}, {6'h00, ~d[7:5]});
            chk({4'h0, res[0]}, {4'h0, d[4:0]});
            chk({4'h0, res[1]}, {4'h0, ~d[4:0]});
        end
        rdc(1'b1, plpc_pkg::CMD_LOOP_COMP, ~d);
        for (int c = 0; c < 8; c++)
        begin
            wr(1'b0, plpc_pkg::CMD_PHASE_CFG, 8'(c), 1'b1);
            chk(deg[0], DEG0[c]);
            chk(deg[1], DEG1[c]);
        end
        rdc(1'b0, plpc_pkg::CMD_PHASE_CFG, 8'h07);
        // Feedback sharing with each sense gain code 0 to 2
        for (int g = 0; g < 3; g++)
        begin
            wr(1'b0, plpc_pkg::CMD_PHASE_CFG, {1'b1, 2'(g), 5'h00}, 1'b1);
            chk({7'h00, gain}, 9'(g));
            chk({8'h00, fb}, 9'h001);
        end
        wr(1'b0, plpc_pkg::CMD_PHASE_CFG, 8'h10, 1'b1);
        chk({8'h00, fb}, 9'h000);
        vin(1'b0, 1'b1, 1'b0);
        repeat (2) @(negedge clk);
        chk({7'h00, sh_lvl, sh_out}, 9'h000);
        vin(1'b0, 1'b0, 1'b0);
        vin(1'b1, 1'b0, 1'b1);
        wr(1'b0, plpc_pkg::CMD_PHASE_CFG, 8'h00, 1'b1);
        vin(1'b1, 1'b1, 1'b1);
        vin(1'b1, 1'b0, 1'b1);
        run_pin     = 2'b01;
        chan_cmd_on = 2'b11;
        repeat (4) @(negedge clk);
        wr(1'b0, plpc_pkg::CMD_PHASE_CFG, 8'h44, 1'b0);
        chk({8'h00, busy}, 9'h001);
        rdc(1'b0, plpc_pkg::CMD_PHASE_CFG, 8'h00);
        wr(1'b0, plpc_pkg::CMD_LOOP_COMP, 8'h70, 1'b1);
        chan_cmd_on = 2'b00;
        @(negedge clk);
        wr(1'b0, plpc_pkg::CMD_PHASE_CFG, 8'h21, 1'b1);
        chk(deg[0], 9'h05A);
        chk({7'h00, gain}, 9'h001);
        busy_fault_clr = 1'b1;
        @(negedge clk);
        busy_fault_clr = 1'b0;
        repeat (2) @(negedge clk);
        chk({8'h00, busy}, 9'h000);
        wr(1'b0, 8'h33, 8'h00, 1'b0);
        @(negedge sync_clk);
        seen = 1'b0;
        repeat (8)
        begin
            @(negedge clk);
            seen = seen | (ph_ref === 1'b1);
        end
        chk({8'h00, seen}, 9'h001);
        chk({7'h00, sh_lvl, sh_out}, 9'h002);
        tally_and_finish();
    end
endmodule
`default_nettype wire
